// ===== usb_irq_defines.svh
// Offsets, field positions, reset values and masks of the USB interrupt block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

// Register indices; the byte address is four times the index
`define SUSP_CTRL_IDX   6'h01
`define IN_FLAGS_IDX    6'h02
`define OUT_FLAGS_IDX   6'h04
`define CMN_FLAGS_IDX   6'h06
`define IN_EN_IDX       6'h07
`define OUT_EN_IDX      6'h08
`define CMN_EN_IDX      6'h0B

// Reset values
`define CMN_EN_RST      8'h06
`define IN_EN_RST       8'h03
`define OUT_EN_RST      8'h02
`define SUSP_CTRL_RST   8'h00
`define FLAGS_RST       8'h00

// Implemented bits of each register
`define CMN_MASK        8'h0F
`define IN_MASK         8'h03
`define OUT_MASK        8'h02
`define SUSP_CTRL_MASK  8'h01

// Field positions of the common registers and of the suspend control register
`define FRAME_START_BIT 3
`define BUS_RESET_BIT   2
`define RESUME_BIT      1
`define SUSPEND_BIT     0
`define SUSP_DET_BIT    0

// Bus constants
`define AXI_ADDR_W      8
`define AXI_DATA_W      32

`endif

// ===== usb_irq_pkg.sv
// Types shared by the USB interrupt flag and enable block.
// Assumes the defines header sits in the same folder.
`default_nettype none
`include "usb_irq_defines.svh"

package usb_irq_pkg;

    // Common bus events from the serial engine, one-cycle pulses
    typedef struct packed {
        logic frame_start;  // Token seen or expected and missed
        logic bus_reset;    // Reset signalling on the bus
        logic resume;       // Resume signalling
        logic suspend;      // Suspend signalling
    } usb_events_t;

    // AXI response codes
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

endpackage : usb_irq_pkg

`default_nettype wire

// ===== flag_bank.sv
// Eight sticky interrupt flags, cleared by a read or by writing ones.
// Assumes set and clear inputs are on aclk; sets win over clears.
`default_nettype none
`include "usb_irq_defines.svh"

module flag_bank #(
    parameter logic [7:0] VALID_MASK = 8'hFF  // Bits that exist
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] set_bits,   // Event pulses
    input  wire logic       rd_clear,   // Register read taken
    input  wire logic [7:0] wr_clear,   // Write-one-to-clear bits
    output logic      [7:0] flags       // Sticky flags
);

    logic [7:0] next_flags;  // Value after this edge

    // Set beats clear so an event at the clearing read is kept
    always_comb begin
        next_flags = flags;
        if (rd_clear) begin
            next_flags = `FLAGS_RST;
        end
        next_flags = (next_flags & ~wr_clear) | set_bits;
        next_flags = next_flags & VALID_MASK;
    end

    // Flag storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= `FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

endmodule : flag_bank

`default_nettype wire

// ===== usb_interrupt_flags_enables.sv
// USB interrupt flags and enables with an AXI4-Lite register slave.
// Assumes event pulses come from the serial engine on aclk.
//
// Contract
// (RULE1) Common enable, four gates, resets to 0x06
// (RULE2) Common enable bits 7..4 read zero
// (RULE3) Enable set lets its event interrupt
// (RULE4) IN enable two bits, resets to 0x03
// (RULE5) OUT enable only bit 1 exists
// (RULE6) Common flags set by frame, reset, resume, suspend
// (RULE7) Reading a flag register clears it
// (RULE8) Enabled set flag raises the interrupt
`default_nettype none
`include "usb_irq_defines.svh"

module usb_interrupt_flags_enables
    import usb_irq_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // Write address channel
    input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // Write data channel
    input  wire logic [`AXI_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // Write response channel
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // Read address channel
    input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // Read data channel
    output logic [`AXI_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Serial engine events
    input  wire usb_events_t            cmn_events,
    input  wire logic                   usb_suspended,
    input  wire logic [1:0]             in_ep_events,
    input  wire logic                   out_ep1_event,
    // Interrupt request, level
    output logic                        usb_irq
);

    // Decode a byte address into a register index; alignment is checked apart
    function automatic logic [5:0] reg_index(input logic [`AXI_ADDR_W-1:0] a);
        reg_index = a[`AXI_ADDR_W-1:2];
    endfunction : reg_index

    // True for an aligned address whose index names a register
    function automatic logic idx_mapped(input logic [`AXI_ADDR_W-1:0] a);
        logic [5:0] i;
        i = reg_index(a);
        idx_mapped = (a[1:0] == 2'h0) &&
                     ((i == `SUSP_CTRL_IDX) || (i == `IN_FLAGS_IDX) ||
                      (i == `OUT_FLAGS_IDX) || (i == `CMN_FLAGS_IDX) ||
                      (i == `IN_EN_IDX) || (i == `OUT_EN_IDX) ||
                      (i == `CMN_EN_IDX));
    endfunction : idx_mapped

    // Software registers
    logic [7:0]             cmn_en;     // Common enables
    logic [7:0]             in_en;      // IN endpoint enables
    logic [7:0]             out_en;     // OUT endpoint enables
    logic [7:0]             susp_ctrl;  // Suspend detection control
    logic [7:0]             cmn_flags;  // Common flags
    logic [7:0]             in_flags;   // IN endpoint flags
    logic [7:0]             out_flags;  // OUT endpoint flags

    // Write channel holding state
    logic                   aw_held;    // Address waiting
    logic                   w_held;     // Data waiting
    logic [`AXI_ADDR_W-1:0] aw_addr;    // Held address
    logic [7:0]             w_byte;     // Held low byte
    logic                   w_lane0;    // Low byte lane strobed
    logic                   wr_fire;    // Write performed now
    logic                   wr_ok;      // Address maps to a register
    logic [5:0]             wr_idx;     // Index of the write

    // Read side
    logic                   rd_fire;    // Read address taken now
    logic [5:0]             rd_idx;     // Index of the read
    logic                   rd_ok;      // Read address names a register
    logic [7:0]             rd_byte;    // Selected register value

    // Flag bank inputs
    logic [7:0]             cmn_set;    // Common set pulses
    logic [7:0]             in_set;     // IN set pulses
    logic [7:0]             out_set;    // OUT set pulses
    logic [7:0]             wr_clr_cmn; // Write-one clears
    logic [7:0]             wr_clr_in;
    logic [7:0]             wr_clr_out;
    logic                   suspend_detect_en;

    assign suspend_detect_en = susp_ctrl[`SUSP_DET_BIT];

    // Handshake outputs; one read and two writes outstanding at most, the second held until bvalid drops
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx  = reg_index(aw_addr);
    assign wr_ok   = idx_mapped(aw_addr);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx  = reg_index(s_axi_araddr);
    // Misaligned reads share an index with a flag register; they must not clear it
    assign rd_ok   = idx_mapped(s_axi_araddr);

    // Capture write address, either order against the data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Capture write data; only the low lane carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response, error for unmapped or misaligned addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Enable and control registers; unused bits never store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmn_en    <= `CMN_EN_RST;     // see (RULE1)
            in_en     <= `IN_EN_RST;      // see (RULE4)
            out_en    <= `OUT_EN_RST;
            susp_ctrl <= `SUSP_CTRL_RST;
        end else if (wr_fire && w_lane0 && wr_ok) begin
            case (wr_idx)
                `CMN_EN_IDX: begin
                    cmn_en <= w_byte & `CMN_MASK;  // see (RULE1) (RULE2)
                end
                `IN_EN_IDX: begin
                    in_en <= w_byte & `IN_MASK;    // see (RULE4)
                end
                `OUT_EN_IDX: begin
                    out_en <= w_byte & `OUT_MASK;  // see (RULE5)
                end
                `SUSP_CTRL_IDX: begin
                    susp_ctrl <= w_byte & `SUSP_CTRL_MASK;
                end
                default: begin
                    // Flag registers handled by the banks
                end
            endcase
        end
    end

    // Event gating; resume counts only while suspended
    always_comb begin
        cmn_set = 8'h00;
        cmn_set[`FRAME_START_BIT] = cmn_events.frame_start;  // see (RULE6)
        cmn_set[`BUS_RESET_BIT]   = cmn_events.bus_reset;    // see (RULE6)
        cmn_set[`RESUME_BIT]      = cmn_events.resume && usb_suspended;
        cmn_set[`SUSPEND_BIT]     = cmn_events.suspend && suspend_detect_en;
        in_set  = {6'h00, in_ep_events};
        out_set = {6'h00, out_ep1_event, 1'b0};
    end

    // Write-one-to-clear masks for each flag register
    always_comb begin
        wr_clr_cmn = 8'h00;
        wr_clr_in  = 8'h00;
        wr_clr_out = 8'h00;
        if (wr_fire && w_lane0 && wr_ok) begin
            case (wr_idx)
                `CMN_FLAGS_IDX: wr_clr_cmn = w_byte;
                `IN_FLAGS_IDX:  wr_clr_in  = w_byte;
                `OUT_FLAGS_IDX: wr_clr_out = w_byte;
                default: begin
                    wr_clr_cmn = 8'h00;
                end
            endcase
        end
    end

    // Common flags, cleared by the read that returns them
    flag_bank #(
        .VALID_MASK (`CMN_MASK)
    ) u_cmn_flags (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_bits (cmn_set),
        .rd_clear (rd_fire && rd_ok && (rd_idx == `CMN_FLAGS_IDX)),  // see (RULE7)
        .wr_clear (wr_clr_cmn),
        .flags    (cmn_flags)
    );

    // IN endpoint flags
    flag_bank #(
        .VALID_MASK (`IN_MASK)
    ) u_in_flags (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_bits (in_set),
        .rd_clear (rd_fire && rd_ok && (rd_idx == `IN_FLAGS_IDX)),   // see (RULE7)
        .wr_clear (wr_clr_in),
        .flags    (in_flags)
    );

    // OUT endpoint flags
    flag_bank #(
        .VALID_MASK (`OUT_MASK)
    ) u_out_flags (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_bits (out_set),
        .rd_clear (rd_fire && rd_ok && (rd_idx == `OUT_FLAGS_IDX)),  // see (RULE7)
        .wr_clear (wr_clr_out),
        .flags    (out_flags)
    );

    // Read mux; the value before any clear is what software sees
    always_comb begin
        rd_byte = 8'h00;
        case (rd_idx)
            `CMN_FLAGS_IDX: rd_byte = cmn_flags;
            `IN_FLAGS_IDX:  rd_byte = in_flags;
            `OUT_FLAGS_IDX: rd_byte = out_flags;
            `CMN_EN_IDX:    rd_byte = cmn_en;   // see (RULE2)
            `IN_EN_IDX:     rd_byte = in_en;
            `OUT_EN_IDX:    rd_byte = out_en;
            `SUSP_CTRL_IDX: rd_byte = susp_ctrl;
            default:        rd_byte = 8'h00;
        endcase
    end

    // Read data register, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_ok ? rd_byte : 8'h00};
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Single request line gated by every enable
    assign usb_irq = (|(cmn_flags & cmn_en)) ||  // see (RULE3) (RULE8)
                     (|(in_flags & in_en)) ||
                     (|(out_flags & out_en));

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    cmn_en_reset_a: assert property ($past(!aresetn) |-> cmn_en == 8'h06) // see (RULE1)
        else $error("common enable reset value wrong");
    cmn_en_unused_a: assert property (cmn_en[7:4] == 4'h0) // see (RULE2)
        else $error("common enable upper bits not zero");
    suspend_block_a: assert property ( // see (RULE3)
        (!cmn_en[0] && cmn_flags == 8'h01 && in_flags == 8'h00 && out_flags == 8'h00)
        |-> !usb_irq)
        else $error("disabled suspend flag raised interrupt");
    in_en_reset_a: assert property ($past(!aresetn) |-> in_en == 8'h03) // see (RULE4)
        else $error("in enable reset value wrong");
    out_en_bits_a: assert property ((out_en & 8'hFD) == 8'h00) // see (RULE5)
        else $error("out enable unused bit set");
    bus_reset_set_a: assert property (cmn_events.bus_reset |=> cmn_flags[2]) // see (RULE6)
        else $error("bus reset flag not set");
    suspend_gate_a: assert property ( // see (RULE6)
        (!cmn_flags[0] && !suspend_detect_en) |=> !cmn_flags[0])
        else $error("suspend flag set while detection off");
    read_clear_a: assert property ( // see (RULE7)
        (rd_fire && rd_ok && rd_idx == 6'h06 && cmn_set == 8'h00) |=> cmn_flags == 8'h00)
        else $error("common flags not cleared by read");
    read_value_a: assert property ( // see (RULE7)
        (rd_fire && rd_ok && rd_idx == 6'h06) |=>
        (s_axi_rvalid && s_axi_rdata[7:0] == $past(cmn_flags)))
        else $error("read did not return flags");
    irq_raise_a: assert property ( // see (RULE8)
        (cmn_events.bus_reset && cmn_en[2] && !wr_fire) |=> usb_irq)
        else $error("enabled flag did not raise interrupt");

    read_clear_c: cover property (rd_fire && rd_idx == 6'h06 && cmn_flags != 8'h00);
    irq_rise_c:   cover property ($rose(usb_irq));
    write_resp_c: cover property (wr_fire ##1 s_axi_bvalid);

endmodule : usb_interrupt_flags_enables

`default_nettype wire

// ===== test_usb_interrupt_flags_enables.sv
// Self-checking bench for the USB interrupt flag and enable block.
// Assumes the defines header, the package and the design files are compiled first.
`default_nettype none
`include "usb_irq_defines.svh"

module test_usb_interrupt_flags_enables
    import usb_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk;          // 40 MHz bench clock
    logic        aresetn;       // Synchronous reset, low
    logic [7:0]  awaddr;        // Write byte address
    logic        awvalid;       // Write address offered
    logic        awready;       // Write address accepted
    logic [31:0] wdata;         // Write word
    logic [3:0]  wstrb;         // Write byte strobes
    logic        wvalid;        // Write data offered
    logic        wready;        // Write data accepted
    logic [1:0]  bresp;         // Write response code
    logic        bvalid;        // Write response offered
    logic        bready;        // Write response taken
    logic [7:0]  araddr;        // Read byte address
    logic        arvalid;       // Read address offered
    logic        arready;       // Read address accepted
    logic [31:0] rdata;         // Read word
    logic [1:0]  rresp;         // Read response code
    logic        rvalid;        // Read data offered
    logic        rready;        // Read data taken
    usb_events_t cmn_events;    // Common event pulses
    logic        usb_suspended; // Suspend state level
    logic [1:0]  in_ep_events;  // IN endpoint pulses
    logic        out_ep1_event; // OUT endpoint 1 pulse
    logic        usb_irq;       // Level interrupt
    int          failures;      // Mismatch count
    int          num_checks;    // Comparison count
    int          cycles;        // Hang guard
    logic [31:0] rd;            // Last read word
    logic [1:0]  rs;            // Last response code

    usb_interrupt_flags_enables u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmn_events(cmn_events),
        .usb_suspended(usb_suspended), .in_ep_events(in_ep_events),
        .out_ep1_event(out_ep1_event), .usb_irq(usb_irq)
    );

    // Free-running clock, 25 ns period
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Cuts a hang short; the whole run needs well under 2000 cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            final_report();
        end
    end

    // One comparison, reported at once on a mismatch
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // AXI4-Lite write; entered just after an edge, leaves one edge of slack
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
        bit done;
        done = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rs = bresp;
                done = 1'b1;
            end
        end
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    // AXI4-Lite read; response and data kept in rs and rd
    task automatic axi_read(input logic [7:0] a);
        bit done;
        done = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                rs = rresp;
                done = 1'b1;
            end
        end
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Read a register and compare data and response
    task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        axi_read(a);
        check(what, rd, {24'h000000, exp});
        check("rresp", {30'h0, rs}, 32'h00000000);
    endtask : read_check

    // One-cycle event pulses on the chosen sources at once
    task automatic pulse(input logic [3:0] c, input logic [1:0] i, input logic o);
        cmn_events    <= usb_events_t'(c);
        in_ep_events  <= i;
        out_ep1_event <= o;
        @(posedge aclk);
        cmn_events    <= '0;
        in_ep_events  <= 2'h0;
        out_ep1_event <= 1'b0;
        @(posedge aclk);
    endtask : pulse

    // Interrupt level, looked at once the edge's updates have landed
    task automatic irq_check(input logic exp);
        #1;
        check("usb_irq", {31'h0, usb_irq}, {31'h0, exp});
        @(posedge aclk);
    endtask : irq_check

    localparam logic [7:0] SUSP_A = {`SUSP_CTRL_IDX, 2'b00}; // Suspend control
    localparam logic [7:0] INF_A  = {`IN_FLAGS_IDX, 2'b00};  // IN flags
    localparam logic [7:0] OUTF_A = {`OUT_FLAGS_IDX, 2'b00}; // OUT flags
    localparam logic [7:0] CMNF_A = {`CMN_FLAGS_IDX, 2'b00}; // Common flags
    localparam logic [7:0] INE_A  = {`IN_EN_IDX, 2'b00};     // IN enables
    localparam logic [7:0] OUTE_A = {`OUT_EN_IDX, 2'b00};    // OUT enables
    localparam logic [7:0] CMNE_A = {`CMN_EN_IDX, 2'b00};    // Common enables

    // Main sequence
    initial begin
        aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h00000000;
        wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
        cmn_events = '0; usb_suspended = 1'b0; in_ep_events = 2'h0; out_ep1_event = 1'b0;
        failures = 0; num_checks = 0; cycles = 0; wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);

        // Reset values, masked writes, unmapped access
        irq_check(1'b0);
        read_check("cmn_en reset", CMNE_A, 8'h06);
        read_check("in_en reset", INE_A, 8'h03);
        read_check("out_en reset", OUTE_A, 8'h02);
        read_check("cmn_flags reset", CMNF_A, 8'h00);
        axi_write(CMNE_A, 8'hFF);
        check("bresp", {30'h0, rs}, 32'h00000000);
        read_check("cmn_en upper bits", CMNE_A, 8'h0F);
        axi_write(INE_A, 8'hFF);
        read_check("in_en unused bits", INE_A, 8'h03);
        axi_write(OUTE_A, 8'hFD);
        read_check("out_en unused bits", OUTE_A, 8'h00);
        axi_write(OUTE_A, 8'hFF);
        read_check("out_en bit1", OUTE_A, 8'h02);
        axi_read(8'h30);
        check("unmapped rresp", {30'h0, rs}, 32'h00000002);
        check("unmapped rdata", rd, 32'h00000000);
        axi_write(8'h30, 8'hFF);
        check("unmapped bresp", {30'h0, rs}, 32'h00000002);
        // A write with its low strobe off changes nothing
        wstrb <= 4'h0;
        axi_write(CMNE_A, 8'h00);
        wstrb <= 4'hF;
        read_check("strobe off", CMNE_A, 8'h0F);
        $display("test registers done");

        // Each common event sets its flag and interrupts; a read clears it
        axi_write(SUSP_A, 8'h01);
        usb_suspended <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            pulse(4'h1 << k, 2'h0, 1'b0);
            irq_check(1'b1);
            read_check("cmn_flags event", CMNF_A, 8'h01 << k);
            irq_check(1'b0);
            read_check("cmn_flags cleared", CMNF_A, 8'h00);
        end
        $display("test common events done");

        // Disabled source holds its flag but not the interrupt
        axi_write(CMNE_A, 8'h00);
        pulse(4'h1, 2'h0, 1'b0);
        irq_check(1'b0);
        axi_write(CMNE_A, 8'h01);
        irq_check(1'b1);
        read_check("masked flag kept", CMNF_A, 8'h01);
        // Writing ones clears; a misaligned read gets an error and zero data and does not clear
        pulse(4'h4, 2'h0, 1'b0);
        axi_write(CMNF_A, 8'h04);
        read_check("write-one clear", CMNF_A, 8'h00);
        pulse(4'h4, 2'h0, 1'b0);
        axi_read(CMNF_A + 8'h01);
        check("misaligned rresp", {30'h0, rs}, 32'h00000002);
        check("misaligned rdata", rd, 32'h00000000);
        read_check("flag after misaligned", CMNF_A, 8'h04);
        // Resume only while suspended, suspend only with detection on
        usb_suspended <= 1'b0;
        axi_write(SUSP_A, 8'h00);
        pulse(4'h3, 2'h0, 1'b0);
        read_check("gated events", CMNF_A, 8'h00);
        $display("test masking done");

        // Endpoint sources and their enables
        pulse(4'h0, 2'h3, 1'b1);
        irq_check(1'b1);
        read_check("in_flags", INF_A, 8'h03);
        read_check("out_flags", OUTF_A, 8'h02);
        irq_check(1'b0);
        axi_write(INE_A, 8'h01);
        pulse(4'h0, 2'h2, 1'b0);
        irq_check(1'b0);
        read_check("in_flags masked", INF_A, 8'h02);
        axi_write(OUTE_A, 8'h00);
        pulse(4'h0, 2'h0, 1'b1);
        irq_check(1'b0);
        axi_write(OUTE_A, 8'h02);
        irq_check(1'b1);
        read_check("out_flags masked", OUTF_A, 8'h02);
        $display("test endpoints done");

        // Mid-run reset drops pending flags and restores the enables
        pulse(4'h4, 2'h1, 1'b0);
        irq_check(1'b1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        irq_check(1'b0);
        read_check("cmn_en after reset", CMNE_A, 8'h06);
        read_check("in_en after reset", INE_A, 8'h03);
        read_check("in_flags after reset", INF_A, 8'h00);
        read_check("cmn_flags after reset", CMNF_A, 8'h00);
        $display("test mid-run reset done");

        final_report();
    end
endmodule : test_usb_interrupt_flags_enables

`default_nettype wire
